// File: src/cvt_pkg.sv
// Shared constants, types and helpers for the calibration vector and trim register group
package cvt_pkg;
	// Vector store geometry
	localparam int unsigned CVT_VEC_LEN = 673;
	localparam int unsigned CVT_IDX_W = 10;
	localparam logic [CVT_IDX_W-1:0] CVT_IDX_FIRST = 10'h000;
	localparam logic [CVT_IDX_W-1:0] CVT_IDX_LAST = 10'h2a0;
	localparam int unsigned CVT_DW = 8;
	localparam int unsigned CVT_FIFO_DEPTH = 16;
	// Wishbone geometry
	localparam int unsigned CVT_ADR_W = 10;
	localparam int unsigned CVT_BUS_W = 32;
	localparam int unsigned CVT_SEL_W = 4;
	localparam int unsigned CVT_REG_LSB = 2;
	localparam int unsigned CVT_REG_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [CVT_REG_W-1:0] CVT_IDX_PORT_EN = 8'h70;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_VEC_PORT = 8'h71;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_CTRL = 8'h72;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_GAIN_A = 8'h7a;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_GAIN_B = 8'h7b;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_BG = 8'h7c;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_TERM_A = 8'h7e;
	localparam logic [CVT_REG_W-1:0] CVT_IDX_TERM_B = 8'h7f;
	// Field positions
	localparam int unsigned CVT_EN_BIT = 0;
	localparam int unsigned CVT_HOLD_BIT = 0;
	localparam int unsigned CVT_HALT_BIT = 1;
	localparam int unsigned CVT_BUSY_BIT = 2;
	localparam int unsigned CVT_BG_W = 4;
	localparam int unsigned CVT_LANE0 = 0;
	// Reset values
	localparam logic CVT_EN_RST = 1'b0;
	localparam logic CVT_HOLD_RST = 1'b0;
	localparam logic [7:0] CVT_GAIN_A_RST = 8'h00;
	localparam logic [7:0] CVT_GAIN_B_RST = 8'h00;
	localparam logic [3:0] CVT_BG_RST = 4'h0;
	localparam logic [7:0] CVT_TERM_A_RST = 8'h00;
	localparam logic [7:0] CVT_TERM_B_RST = 8'h00;
	localparam logic [31:0] CVT_DAT_RST = 32'h0000_0000;

	typedef enum logic [1:0] {CVT_IDLE, CVT_RDWAIT, CVT_ACK} cvt_state_type;

	function automatic logic [CVT_IDX_W-1:0] cvt_next_idx(input logic [CVT_IDX_W-1:0] idx);
		cvt_next_idx = (idx == CVT_IDX_LAST) ? CVT_IDX_FIRST : idx + 10'h001;
	endfunction

	function automatic logic [CVT_BUS_W-1:0] cvt_word(input logic [7:0] b);
		cvt_word = {24'h00_0000, b};
	endfunction
endpackage

// File: src/cvt_strm_if.sv
// Valid/ready byte stream between the register front end and the write buffer
`timescale 1ns/1ps
`default_nettype none
interface cvt_strm_if #(parameter int unsigned W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: src/cvt_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cvt_fifo import cvt_pkg::*; #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Streams
	cvt_strm_if.snk in_s,
	cvt_strm_if.src out_s
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_s.ready = (cnt_q != FULL);
	assign out_s.valid = (cnt_q != '0);
	assign out_s.data = mem_q[rd_q];
	assign push = in_s.valid & in_s.ready & ce_i;
	assign pop = out_s.valid & out_s.ready & ce_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_s.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// File: src/cvt_vec_mem.sv
// Calibration vector store, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module cvt_vec_mem import cvt_pkg::*; (
	// Clock
	input wire logic clk_i,
	input wire logic ce_i,
	// Write port
	input wire logic we_i,
	input wire logic [CVT_IDX_W-1:0] waddr_i,
	input wire logic [CVT_DW-1:0] wdata_i,
	// Read port
	input wire logic re_i,
	input wire logic [CVT_IDX_W-1:0] raddr_i,
	output logic [CVT_DW-1:0] rdata_o
);
	// Contents are never reset: software must restore a saved vector
	logic [CVT_DW-1:0] mem_q [CVT_VEC_LEN];

	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && re_i) begin
			rdata_o <= mem_q[raddr_i];
		end
	end
endmodule
`default_nettype wire

// File: src/cvt_regs.sv
// Calibration vector port and factory trim registers behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module cvt_regs import cvt_pkg::*; (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [CVT_ADR_W-1:0] adr_i,
	input wire logic [CVT_SEL_W-1:0] sel_i,
	input wire logic [CVT_BUS_W-1:0] dat_i,
	output logic [CVT_BUS_W-1:0] dat_o,
	output logic ack_o,
	// Calibration engine status
	input wire logic calibration_halted_flag_i,
	// Trim outputs to the analog front end
	output logic [7:0] input_a_gain_trim_o,
	output logic [7:0] input_b_gain_trim_o,
	output logic [CVT_BG_W-1:0] bandgap_reference_trim_o,
	output logic [7:0] input_a_termination_trim_o,
	output logic [7:0] input_b_termination_trim_o
);
	cvt_state_type state_q;
	logic [CVT_BUS_W-1:0] dat_q;
	logic port_en_q;
	logic addr_hold_q;
	logic [CVT_IDX_W-1:0] idx_q;
	logic [7:0] gain_a_q;
	logic [7:0] gain_b_q;
	logic [CVT_BG_W-1:0] bg_q;
	logic [7:0] term_a_q;
	logic [7:0] term_b_q;

	logic [CVT_REG_W-1:0] reg_idx;
	logic req;
	logic wr0;
	logic hit_vec;
	logic fifo_empty;
	logic posted_wr;
	logic direct_wr;
	logic vec_rd;
	logic en_wr;
	logic go;
	logic drain;
	logic mem_we;
	logic [CVT_IDX_W-1:0] mem_waddr;
	logic [CVT_DW-1:0] mem_wdata;
	logic [CVT_DW-1:0] mem_rdata;
	logic [CVT_BUS_W-1:0] rd_mux;

	cvt_strm_if #(.W(CVT_DW)) push_s ();
	cvt_strm_if #(.W(CVT_DW)) pop_s ();

	// Request decode
	assign reg_idx = adr_i[CVT_REG_LSB +: CVT_REG_W];
	assign req = cyc_i & stb_i & (state_q == CVT_IDLE) & ce_i;
	assign wr0 = we_i & sel_i[CVT_LANE0];
	assign hit_vec = (reg_idx == CVT_IDX_VEC_PORT) & port_en_q;
	assign fifo_empty = ~pop_s.valid;
	// Posted burst writes only while address hold is set
	assign posted_wr = req & hit_vec & wr0 & addr_hold_q;
	assign direct_wr = req & hit_vec & wr0 & ~addr_hold_q & fifo_empty;
	// Reads wait for posted writes to drain so the order stays intact
	assign vec_rd = req & hit_vec & ~we_i & fifo_empty;
	assign en_wr = req & wr0 & (reg_idx == CVT_IDX_PORT_EN) & fifo_empty;

	always_comb begin
		go = req;
		if (hit_vec) begin
			if (wr0 && addr_hold_q) begin
				go = req & push_s.ready;
			end else if (we_i && !wr0) begin
				go = req;
			end else begin
				go = req & fifo_empty;
			end
		end else if (reg_idx == CVT_IDX_PORT_EN && wr0) begin
			go = en_wr;
		end
	end

	// Write buffer for streamed vector bytes
	assign push_s.valid = posted_wr;
	assign push_s.data = dat_i[CVT_DW-1:0];
	// Buffered bytes only commit while calibration is halted, protecting the engine
	assign pop_s.ready = calibration_halted_flag_i;
	assign drain = pop_s.valid & pop_s.ready & ce_i;

	cvt_fifo #(.WIDTH(CVT_DW), .DEPTH(CVT_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_s(push_s),
		.out_s(pop_s)
	);

	// Vector store access at the running index
	assign mem_we = drain | direct_wr;
	assign mem_waddr = idx_q;
	assign mem_wdata = drain ? pop_s.data : dat_i[CVT_DW-1:0];

	cvt_vec_mem u_mem (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.re_i(vec_rd),
		.raddr_i(idx_q),
		.rdata_o(mem_rdata)
	);

	// Running vector index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_q <= CVT_IDX_FIRST;
		end else if (ce_i) begin
			// Restart and advance never meet: the enable write waits for an empty buffer
			if (en_wr && dat_i[CVT_EN_BIT] && !port_en_q) begin
				idx_q <= CVT_IDX_FIRST;
			end else if (mem_we || vec_rd) begin
				idx_q <= cvt_next_idx(idx_q);
			end
		end
	end

	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_en_q <= CVT_EN_RST;
			addr_hold_q <= CVT_HOLD_RST;
		end else if (ce_i && req && wr0) begin
			if (en_wr) begin
				port_en_q <= dat_i[CVT_EN_BIT];
			end
			if (reg_idx == CVT_IDX_CTRL) begin
				addr_hold_q <= dat_i[CVT_HOLD_BIT];
			end
		end
	end

	// Trim registers, loaded with factory values at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gain_a_q <= CVT_GAIN_A_RST;
			gain_b_q <= CVT_GAIN_B_RST;
			bg_q <= CVT_BG_RST;
			term_a_q <= CVT_TERM_A_RST;
			term_b_q <= CVT_TERM_B_RST;
		end else if (ce_i && req && wr0) begin
			case (reg_idx)
				CVT_IDX_GAIN_A: begin
					gain_a_q <= dat_i[7:0];
				end
				CVT_IDX_GAIN_B: begin
					gain_b_q <= dat_i[7:0];
				end
				CVT_IDX_BG: begin
					bg_q <= dat_i[CVT_BG_W-1:0];
				end
				CVT_IDX_TERM_A: begin
					term_a_q <= dat_i[7:0];
				end
				CVT_IDX_TERM_B: begin
					term_b_q <= dat_i[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	assign input_a_gain_trim_o = gain_a_q;
	assign input_b_gain_trim_o = gain_b_q;
	assign bandgap_reference_trim_o = bg_q;
	assign input_a_termination_trim_o = term_a_q;
	assign input_b_termination_trim_o = term_b_q;

	// Read multiplexer; reserved bits and unmapped indices read zero
	always_comb begin
		rd_mux = CVT_DAT_RST;
		case (reg_idx)
			CVT_IDX_PORT_EN: begin
				rd_mux[CVT_EN_BIT] = port_en_q;
			end
			CVT_IDX_CTRL: begin
				rd_mux[CVT_HOLD_BIT] = addr_hold_q;
				rd_mux[CVT_HALT_BIT] = calibration_halted_flag_i;
				rd_mux[CVT_BUSY_BIT] = ~fifo_empty;
			end
			CVT_IDX_GAIN_A: begin
				rd_mux = cvt_word(gain_a_q);
			end
			CVT_IDX_GAIN_B: begin
				rd_mux = cvt_word(gain_b_q);
			end
			CVT_IDX_BG: begin
				rd_mux = cvt_word({4'h0, bg_q});
			end
			CVT_IDX_TERM_A: begin
				rd_mux = cvt_word(term_a_q);
			end
			CVT_IDX_TERM_B: begin
				rd_mux = cvt_word(term_b_q);
			end
			default: begin
				rd_mux = CVT_DAT_RST;
			end
		endcase
	end

	// Bus handshake: one ack per request, vector reads take one extra cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= CVT_IDLE;
		end else if (ce_i) begin
			case (state_q)
				CVT_IDLE: begin
					if (vec_rd) begin
						state_q <= CVT_RDWAIT;
					end else if (go) begin
						state_q <= CVT_ACK;
					end
				end
				CVT_RDWAIT: begin
					state_q <= CVT_ACK;
				end
				CVT_ACK: begin
					state_q <= CVT_IDLE;
				end
				default: begin
					state_q <= CVT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= CVT_DAT_RST;
		end else if (ce_i) begin
			if (state_q == CVT_RDWAIT) begin
				dat_q <= cvt_word(mem_rdata);
			end else if (go && !vec_rd) begin
				// Write acks carry zero so a stale read value never looks fresh
				dat_q <= (we_i || hit_vec) ? CVT_DAT_RST : rd_mux;
			end
		end
	end

	assign dat_o = dat_q;
	assign ack_o = (state_q == CVT_ACK);

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	a_ack_single_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_port_disabled_idle: assert property (mem_we |-> port_en_q || drain)
		else $error("vector store written while port disabled");
	a_vec_read_latency: assert property (vec_rd |-> ##1 state_q == CVT_RDWAIT ##1 ack_o)
		else $error("vector read not answered two cycles later");
	a_read_advances_index: assert property (vec_rd |=> idx_q == cvt_next_idx($past(idx_q)))
		else $error("vector index did not advance on read");
	a_write_same_order: assert property (direct_wr |=> idx_q == cvt_next_idx($past(idx_q)))
		else $error("vector index did not advance on write");
	a_hold_posted_ack: assert property (posted_wr && push_s.ready |=> ack_o)
		else $error("posted burst write not acked next cycle");
	a_enable_restarts_idx: assert property (
		en_wr && dat_i[CVT_EN_BIT] && !port_en_q |=> idx_q == CVT_IDX_FIRST && port_en_q)
		else $error("index not restarted on enable");
	a_gain_a_update: assert property (
		req && wr0 && reg_idx == CVT_IDX_GAIN_A |=> gain_a_q == $past(dat_i[7:0]))
		else $error("input A gain trim write lost");
	a_gain_b_update: assert property (
		req && wr0 && reg_idx == CVT_IDX_GAIN_B |=> gain_b_q == $past(dat_i[7:0]))
		else $error("input B gain trim write lost");
	a_bg_reserved_zero: assert property (
		ack_o && $past(reg_idx) == CVT_IDX_BG && !$past(we_i) |-> dat_o[7:4] == 4'h0)
		else $error("band-gap reserved bits not zero");
	a_bg_update: assert property (
		req && wr0 && reg_idx == CVT_IDX_BG |=> bg_q == $past(dat_i[CVT_BG_W-1:0]))
		else $error("band-gap trim write lost");
	a_term_a_update: assert property (
		req && wr0 && reg_idx == CVT_IDX_TERM_A |=> term_a_q == $past(dat_i[7:0]))
		else $error("input A termination trim write lost");
	a_term_b_update: assert property (
		req && wr0 && reg_idx == CVT_IDX_TERM_B |=> term_b_q == $past(dat_i[7:0]))
		else $error("input B termination trim write lost");

	// Port gating, ordering and handshake checks
	// A disabled port reads as an unmapped word, so a stray read leaks nothing
	a_disabled_port_zero: assert property (
		req && !we_i && !port_en_q && reg_idx == CVT_IDX_VEC_PORT
			|=> ack_o && dat_o == CVT_DAT_RST)
		else $error("disabled vector port read returned data");
	a_port_en_write: assert property (en_wr |=> port_en_q == $past(dat_i[CVT_EN_BIT]))
		else $error("port enable write lost");
	a_ctrl_hold_write: assert property (
		req && wr0 && reg_idx == CVT_IDX_CTRL |=> addr_hold_q == $past(dat_i[CVT_HOLD_BIT]))
		else $error("address hold write lost");
	// A full buffer holds the bus rather than dropping a byte
	a_full_stalls_burst: assert property (posted_wr && !push_s.ready |=> !ack_o)
		else $error("burst write acked while the buffer was full");
	// Buffered bytes land in the same order as direct writes
	a_drain_advances_index: assert property (
		drain |=> idx_q == cvt_next_idx($past(idx_q)))
		else $error("buffered vector byte did not advance the index");
	// Wrap keeps a second pass aligned with the first entry
	a_index_wraps: assert property (
		(mem_we || vec_rd) && idx_q == CVT_IDX_LAST |=> idx_q == CVT_IDX_FIRST)
		else $error("vector index did not wrap after the last entry");
	a_taken_ack_next: assert property (go && !vec_rd |=> ack_o)
		else $error("accepted request not acked next cycle");
	a_write_ack_zero: assert property (ack_o && $past(we_i) |-> dat_o == CVT_DAT_RST)
		else $error("write acknowledged with nonzero read data");

	c_vector_read: cover property (vec_rd ##2 ack_o);
	c_burst_fill: cover property (posted_wr && !push_s.ready);
	c_index_wrap: cover property (mem_we && idx_q == CVT_IDX_LAST);
	c_trim_write: cover property (req && wr0 && reg_idx == CVT_IDX_BG);
	c_direct_restore: cover property (direct_wr && idx_q == CVT_IDX_LAST);
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the calibration vector port and trim registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cvt_pkg::*;
	localparam int LIMIT = 40000;
	typedef struct {logic [7:0] idx; logic [7:0] wval; logic [7:0] rexp;} cvt_row_type;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [CVT_ADR_W-1:0] adr_i = 10'h000;
	logic [CVT_SEL_W-1:0] sel_i = 4'hf;
	logic [CVT_BUS_W-1:0] dat_i = 32'h0000_0000;
	logic [CVT_BUS_W-1:0] dat_o;
	logic ack_o;
	logic halted = 1'b1;
	logic ce = 1'b1;
	logic [7:0] ga, gb, ta, tb;
	logic [3:0] bg;
	logic [3:0] wsel = 4'hf;
	logic [7:0] rd;
	int lat;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	cvt_row_type rows [6];

	cvt_regs i_cvt_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.calibration_halted_flag_i(halted), .input_a_gain_trim_o(ga), .input_b_gain_trim_o(gb),
		.bandgap_reference_trim_o(bg), .input_a_termination_trim_o(ta),
		.input_b_termination_trim_o(tb));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang in a bus wait ends here rather than stalling the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Classic cycle; caller enters just after a rising edge
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h00_0000, wd};
		sel_i <= wsel;
		lat = 0;
		do begin
			@(posedge clk_i);
			lat++;
		end while (ack_o !== 1'b1);
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk(name, {24'h0, exp}, {24'h0, rd});
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	function automatic logic [7:0] pat_a(input int i);
		return 8'(i) ^ 8'h5a;
	endfunction

	function automatic logic [7:0] pat_b(input int i);
		return 8'(i * 3 + 1);
	endfunction

	initial begin
		rows[0] = '{CVT_IDX_GAIN_A, 8'ha5, 8'ha5};
		rows[1] = '{CVT_IDX_GAIN_B, 8'h3c, 8'h3c};
		rows[2] = '{CVT_IDX_BG, 8'hff, 8'h0f};
		rows[3] = '{CVT_IDX_TERM_A, 8'h81, 8'h81};
		rows[4] = '{CVT_IDX_TERM_B, 8'h7e, 8'h7e};
		rows[5] = '{8'h40, 8'h55, 8'h00};
		do_reset();
		foreach (rows[k]) rd_chk("reset value", rows[k].idx, 8'h00);
		chk("trim outputs at reset", 32'h0, {ga, gb, ta, tb} | {28'h0, bg});
		$display("test reset values done");
		foreach (rows[k]) begin
			wb(1'b1, rows[k].idx, rows[k].wval);
			rd_chk("register readback", rows[k].idx, rows[k].rexp);
		end
		chk("trim outputs", 32'ha53c_817e, {ga, gb, ta, tb});
		chk("band-gap trim output", 32'h0000_000f, {28'h0, bg});
		$display("test register table done");
		wsel = 4'he;
		wb(1'b1, CVT_IDX_GAIN_A, 8'h11);
		wsel = 4'hf;
		rd_chk("write with lane 0 off", CVT_IDX_GAIN_A, 8'ha5);
		rd_chk("port read while disabled", CVT_IDX_VEC_PORT, 8'h00);
		$display("test byte enable and disabled port done");
		wb(1'b1, CVT_IDX_PORT_EN, 8'h01);
		rd_chk("port enable", CVT_IDX_PORT_EN, 8'h01);
		for (int i = 0; i < CVT_VEC_LEN; i++) begin
			wb(1'b1, CVT_IDX_VEC_PORT, pat_a(i));
		end
		wb(1'b1, CVT_IDX_PORT_EN, 8'h00);
		wb(1'b1, CVT_IDX_PORT_EN, 8'h01);
		for (int i = 0; i < CVT_VEC_LEN; i++) begin
			rd_chk("vector read", CVT_IDX_VEC_PORT, pat_a(i));
		end
		rd_chk("vector wrap", CVT_IDX_VEC_PORT, pat_a(0));
		$display("test direct vector save and restore done");
		// Stalled engine: posted bytes pile up until the buffer refuses
		halted <= 1'b0;
		wb(1'b1, CVT_IDX_CTRL, 8'h01);
		wb(1'b1, CVT_IDX_PORT_EN, 8'h00);
		wb(1'b1, CVT_IDX_PORT_EN, 8'h01);
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, CVT_IDX_VEC_PORT, pat_b(i));
			chk("posted write latency", 32'd2, lat);
		end
		rd_chk("status with full buffer", CVT_IDX_CTRL, 8'h05);
		fork
			begin
				repeat (40) @(posedge clk_i);
				halted <= 1'b1;
			end
		join_none
		wb(1'b1, CVT_IDX_VEC_PORT, pat_b(16));
		chk("write held while full", 32'd1, 32'(lat > 40));
		for (int i = 17; i < CVT_VEC_LEN; i++) wb(1'b1, CVT_IDX_VEC_PORT, pat_b(i));
		wb(1'b1, CVT_IDX_CTRL, 8'h00);
		wb(1'b1, CVT_IDX_PORT_EN, 8'h00);
		wb(1'b1, CVT_IDX_PORT_EN, 8'h01);
		for (int i = 0; i < CVT_VEC_LEN; i++) begin
			rd_chk("burst readback", CVT_IDX_VEC_PORT, pat_b(i));
		end
		rd_chk("status drained", CVT_IDX_CTRL, 8'h02);
		$display("test streaming burst done");
		// Clock enable low must freeze the bus front end until it returns
		fork
			begin
				ce <= 1'b0;
				repeat (10) @(posedge clk_i);
				ce <= 1'b1;
			end
		join_none
		wb(1'b1, CVT_IDX_GAIN_A, 8'h6b);
		chk("write frozen by clock enable", 32'd1, 32'(lat > 10));
		rd_chk("write after clock enable", CVT_IDX_GAIN_A, 8'h6b);
		$display("test clock enable done");
		wb(1'b1, CVT_IDX_GAIN_B, 8'h99);
		do_reset();
		rd_chk("gain after second reset", CVT_IDX_GAIN_B, 8'h00);
		rd_chk("enable after second reset", CVT_IDX_PORT_EN, 8'h00);
		$display("test second reset done");
		conclude();
	end
endmodule
`default_nettype wire
